// File: design/crs_params.svh
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH
// ==================================================
// reset values and fixed fields
`define CRS_PC_RST 14'h0000
`define CRS_COND_RST 1'b1
`define CRS_SP_RST 10'h3FF
`define CRS_SP_STEP 10'h004
`define CRS_LVL_TOP 4'hF
`define CRS_SP_HI 4'hF
`define CRS_SP_LO 2'h3
// ==================================================
// register byte addresses
`define CRS_A_GPR 12'h000
`define CRS_A_FLAGS 12'h01C
`define CRS_A_PC 12'h020
`define CRS_A_SP 12'h024
`define CRS_A_STKCTL 12'h028
`define CRS_A_IE 12'h02C
`define CRS_A_IREQ 12'h030
`define CRS_A_IMASK 12'h034
`define CRS_A_PLATCH 12'h038
`define CRS_A_PDIR 12'h03C
`define CRS_A_PMODE 12'h040
`define CRS_A_EDGE 12'h044
`define CRS_A_TMR_AB 12'h048
`define CRS_A_TMR_CD 12'h04C
// ==================================================
// implemented-bit masks
`define CRS_M_IE 32'h0000_0001
`define CRS_M_PMODE 32'h0000_0B73
`define CRS_M_EDGE 32'h0000_030F
`define CRS_M_TMR_AB 32'h0000_03FF
`define CRS_M_TMR_CD 32'h0000_FF7F
`define CRS_M_PAGE 4'h3
`define CRS_M_NIB 4'hF
`endif

// File: design/crs_pkg.sv
package crs_pkg;
	// ==================================================
	// core-side write targets, in register-address order
	typedef enum logic [2:0] {
		crs_dst_acc,
		crs_dst_second,
		crs_dst_page,
		crs_dst_col,
		crs_dst_row,
		crs_dst_aux_col,
		crs_dst_aux_row
	} crs_dst_e;
	// ==================================================
	// overflow bit update sources
	typedef enum logic [2:0] {
		crs_ovf_none,
		crs_ovf_arith,
		crs_ovf_set,
		crs_ovf_clear,
		crs_ovf_rotate
	} crs_ovf_e;
endpackage

// File: design/crs_core_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "crs_params.svh"
// Functional notes
// - accumulator and second data register are four bits, loaded by core results
// - page plus column and row pointers form RAM address; row selects D bit
// - two four-bit auxiliary pointers supplement column and row pointers
// - overflow bit takes arithmetic carry and set, clear, rotate effects
// - overflow bit pushed on interrupt, restored by interrupt return only
// - condition latch takes overflow, not-zero or bit test, holds until next
// - condition latch forced to one when a conditional jump or call is fetched
// - condition latch pushed on interrupt, restored by interrupt return only
// - program counter is fourteen bits, address of current instruction
// - stack pointer is ten bits, next free slot, reset to 3FF
// - push lowers stack pointer by four, pop raises it by four
// - top four stack pointer bits fixed at ones, sixteen levels
// - clearing the stack reset bit reloads stack pointer with 3FF
// - reset gives program counter zero, condition latch one, stack pointer 3FF
// - reset clears interrupt enable and requests, sets all masks
// - reset sets port output latches, clears direction bits
// - reset clears port mode and edge select settings
// - reset clears all timer mode settings
module crs_core_regs #(
	parameter int NUM_INT = 10,
	parameter int PORT_W = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic core_wr_i,
	input wire crs_pkg::crs_dst_e core_wr_sel_i,
	input wire logic [3:0] core_wr_data_i,
	input wire crs_pkg::crs_ovf_e ovf_op_i,
	input wire logic ovf_in_i,
	input wire logic cond_upd_i,
	input wire logic cond_in_i,
	input wire logic cond_branch_fetch_i,
	input wire logic pc_load_i,
	input wire logic [13:0] pc_load_val_i,
	input wire logic pc_inc_i,
	input wire logic push_i,
	input wire logic [13:0] push_pc_i,
	input wire logic rtn_i,
	input wire logic interrupt_return_op_i,
	input wire logic stack_bit_clr_i,
	input wire logic [NUM_INT-1:0] int_req_set_i,
	output logic [3:0] acc_o,
	output logic [3:0] second_o,
	output logic [9:0] ram_addr_o,
	output logic [3:0] d_bit_sel_o,
	output logic [3:0] aux_col_o,
	output logic [3:0] aux_row_o,
	output logic overflow_o,
	output logic cond_o,
	output logic [13:0] pc_o,
	output logic [9:0] sp_o,
	output logic int_enable_o,
	output logic [NUM_INT-1:0] int_req_o,
	output logic [NUM_INT-1:0] int_mask_o,
	output logic [PORT_W-1:0] port_latch_o,
	output logic [PORT_W-1:0] port_dir_o,
	output logic [11:0] port_mode_o,
	output logic [9:0] edge_sel_o,
	output logic [9:0] timer_ab_o,
	output logic [15:0] timer_cd_o
);
	// ==================================================
	// register decode
	localparam int NGPR = 7;
	localparam int NCFG = 8;
	localparam int CFG_IE = 0;
	localparam int CFG_IMASK = 1;
	localparam int CFG_PLATCH = 2;
	localparam int CFG_PDIR = 3;

	function automatic logic [11:0] cfg_addr(input int i);
		case (i)
			0: cfg_addr = `CRS_A_IE;
			1: cfg_addr = `CRS_A_IMASK;
			2: cfg_addr = `CRS_A_PLATCH;
			3: cfg_addr = `CRS_A_PDIR;
			4: cfg_addr = `CRS_A_PMODE;
			5: cfg_addr = `CRS_A_EDGE;
			6: cfg_addr = `CRS_A_TMR_AB;
			default: cfg_addr = `CRS_A_TMR_CD;
		endcase
	endfunction

	function automatic logic [31:0] cfg_mask(input int i);
		case (i)
			0: cfg_mask = `CRS_M_IE;
			1: cfg_mask = (32'h1 << NUM_INT) - 32'h1;
			2, 3: cfg_mask = (32'h1 << PORT_W) - 32'h1;
			4: cfg_mask = `CRS_M_PMODE;
			5: cfg_mask = `CRS_M_EDGE;
			6: cfg_mask = `CRS_M_TMR_AB;
			default: cfg_mask = `CRS_M_TMR_CD;
		endcase
	endfunction

	function automatic logic [11:0] gpr_addr(input int i);
		gpr_addr = `CRS_A_GPR + 12'(i * 4);
	endfunction

	logic apb_wr;
	logic apb_setup;
	logic [3:0] gpr [NGPR];
	logic [31:0] cfg [NCFG];
	logic [NUM_INT-1:0] ireq;
	logic ovf;
	logic cond;
	logic [13:0] pc;
	logic [3:0] lvl;
	logic [3:0] pop_lvl;
	logic [3:0] stack_mem [64];
	logic [3:0] w0, w1, w2, w3;
	logic pop;
	logic stk_clr;
	logic [31:0] rd_data;
	logic rd_hit;

	// zero wait states: every transfer ends in its first access cycle
	assign pready_o = 1'b1;
	assign apb_wr = psel_i & penable_i & pwrite_i;
	assign apb_setup = psel_i & ~penable_i;
	assign pop = rtn_i | interrupt_return_op_i;
	assign pop_lvl = lvl + 4'h1;
	assign stk_clr = stack_bit_clr_i
		| (apb_wr & (paddr_i == `CRS_A_STKCTL) & ~pwdata_i[0]);

	// ==================================================
	// data and pointer registers
	generate
		for (genvar g = 0; g < NGPR; g++) begin : g_gpr
			always_ff @(posedge core_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					gpr[g] <= 4'h0;
				end else if (core_wr_i && core_wr_sel_i == crs_pkg::crs_dst_e'(g)) begin
					gpr[g] <= core_wr_data_i & ((g == 2) ? `CRS_M_PAGE : `CRS_M_NIB);
				end else if (apb_wr && paddr_i == gpr_addr(g)) begin
					gpr[g] <= pwdata_i[3:0] & ((g == 2) ? `CRS_M_PAGE : `CRS_M_NIB);
				end
			end
		end
	endgenerate

	assign acc_o = gpr[0];
	assign second_o = gpr[1];
	assign ram_addr_o = {gpr[2][1:0], gpr[3], gpr[4]};
	assign d_bit_sel_o = gpr[4];
	assign aux_col_o = gpr[5];
	assign aux_row_o = gpr[6];

	// ==================================================
	// mode and control settings
	generate
		for (genvar g = 0; g < NCFG; g++) begin : g_cfg
			always_ff @(posedge core_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					// masks all set, latches all ones, everything else cleared
					cfg[g] <= (g == CFG_IMASK || g == CFG_PLATCH) ? cfg_mask(g) : 32'h0;
				end else if (apb_wr && paddr_i == cfg_addr(g)) begin
					cfg[g] <= pwdata_i & cfg_mask(g);
				end
			end
		end
	endgenerate

	assign int_enable_o = cfg[CFG_IE][0];
	assign int_mask_o = cfg[CFG_IMASK][NUM_INT-1:0];
	assign port_latch_o = cfg[CFG_PLATCH][PORT_W-1:0];
	assign port_dir_o = cfg[CFG_PDIR][PORT_W-1:0];
	assign port_mode_o = cfg[4][11:0];
	assign edge_sel_o = cfg[5][9:0];
	assign timer_ab_o = cfg[6][9:0];
	assign timer_cd_o = cfg[7][15:0];

	// a request arriving with a software clear is kept
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ireq <= '0;
		end else if (apb_wr && paddr_i == `CRS_A_IREQ) begin
			ireq <= pwdata_i[NUM_INT-1:0] | int_req_set_i;
		end else begin
			ireq <= ireq | int_req_set_i;
		end
	end
	assign int_req_o = ireq;

	// ==================================================
	// stack
	// stack memory has no reset; contents are only valid once pushed
	assign w0 = stack_mem[{pop_lvl, 2'h0}];
	assign w1 = stack_mem[{pop_lvl, 2'h1}];
	assign w2 = stack_mem[{pop_lvl, 2'h2}];
	assign w3 = stack_mem[{pop_lvl, 2'h3}];

	always_ff @(posedge core_clk_i) begin
		if (push_i && !pop) begin
			stack_mem[{lvl, 2'h0}] <= {cond, push_pc_i[13:11]};
			stack_mem[{lvl, 2'h1}] <= push_pc_i[10:7];
			stack_mem[{lvl, 2'h2}] <= {ovf, push_pc_i[6:4]};
			stack_mem[{lvl, 2'h3}] <= push_pc_i[3:0];
		end
	end

	// a seventeenth push wraps and overwrites the oldest level
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lvl <= `CRS_LVL_TOP;
		end else if (stk_clr) begin
			lvl <= `CRS_LVL_TOP;
		end else if (pop) begin
			lvl <= pop_lvl;
		end else if (push_i) begin
			lvl <= lvl - 4'h1;
		end
	end
	assign sp_o = {`CRS_SP_HI, lvl, `CRS_SP_LO};

	// ==================================================
	// program counter and flags
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc <= `CRS_PC_RST;
		end else if (pop) begin
			pc <= {w0[2:0], w1, w2[2:0], w3};
		end else if (pc_load_i) begin
			pc <= pc_load_val_i;
		end else if (pc_inc_i) begin
			pc <= pc + 14'h1;
		end
	end
	assign pc_o = pc;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cond <= `CRS_COND_RST;
		end else if (interrupt_return_op_i) begin
			cond <= w0[3];
		end else if (cond_branch_fetch_i) begin
			cond <= 1'b1;
		end else if (cond_upd_i) begin
			cond <= cond_in_i;
		end
	end
	assign cond_o = cond;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovf <= 1'b0;
		end else if (interrupt_return_op_i) begin
			ovf <= w2[3];
		end else begin
			case (ovf_op_i)
				crs_pkg::crs_ovf_arith, crs_pkg::crs_ovf_rotate: ovf <= ovf_in_i;
				crs_pkg::crs_ovf_set: ovf <= 1'b1;
				crs_pkg::crs_ovf_clear: ovf <= 1'b0;
				default: begin
					if (apb_wr && paddr_i == `CRS_A_FLAGS) begin
						ovf <= pwdata_i[0];
					end
				end
			endcase
		end
	end
	assign overflow_o = ovf;

	// ==================================================
	// bus read path, captured in the setup cycle
	always_comb begin
		rd_data = 32'h0;
		rd_hit = 1'b1;
		case (paddr_i)
			`CRS_A_FLAGS: rd_data = {30'h0, cond, ovf};
			`CRS_A_PC: rd_data = {18'h0, pc};
			`CRS_A_SP: rd_data = {22'h0, sp_o};
			`CRS_A_STKCTL: rd_data = 32'h0;
			`CRS_A_IREQ: rd_data = 32'(ireq);
			default: rd_hit = 1'b0;
		endcase
		for (int i = 0; i < NGPR; i++) begin
			if (paddr_i == gpr_addr(i)) begin
				rd_data = {28'h0, gpr[i]};
				rd_hit = 1'b1;
			end
		end
		for (int i = 0; i < NCFG; i++) begin
			if (paddr_i == cfg_addr(i)) begin
				rd_data = cfg[i];
				rd_hit = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_o <= 32'h0;
			pslverr_o <= 1'b0;
		end else if (apb_setup) begin
			prdata_o <= pwrite_i ? 32'h0 : rd_data;
			pslverr_o <= ~rd_hit;
		end
	end

	// ==================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sp_fixed_bits_a: assert property (sp_o[9:6] == `CRS_SP_HI && sp_o[1:0] == `CRS_SP_LO)
		else $error("stack pointer fixed bits wrong");
	sp_push_step_a: assert property (push_i && !pop && !stk_clr && lvl != 4'h0 |=> sp_o == $past(sp_o) - `CRS_SP_STEP)
		else $error("push did not lower stack pointer by four");
	sp_pop_step_a: assert property (pop && !stk_clr && lvl != 4'hF |=> sp_o == $past(sp_o) + `CRS_SP_STEP)
		else $error("pop did not raise stack pointer by four");
	stack_reload_a: assert property (stack_bit_clr_i |=> sp_o == `CRS_SP_RST)
		else $error("stack reset bit clear did not reload pointer");
	cond_fetch_force_a: assert property (cond_branch_fetch_i && !interrupt_return_op_i |=> cond_o)
		else $error("condition latch not forced on branch fetch");
	cond_hold_a: assert property (!cond_upd_i && !cond_branch_fetch_i && !interrupt_return_op_i |=> $stable(cond_o))
		else $error("condition latch changed without cause");
	rtn_keeps_flags_a: assert property (rtn_i && !interrupt_return_op_i && ovf_op_i == crs_pkg::crs_ovf_none
		&& !(apb_wr && paddr_i == `CRS_A_FLAGS) && !cond_upd_i && !cond_branch_fetch_i
		|=> $stable(overflow_o) && $stable(cond_o))
		else $error("plain return altered flags");
	call_return_a: assert property ((push_i && !pop && !stk_clr) ##1 (interrupt_return_op_i && !push_i && !stk_clr)
		|=> pc_o == $past(push_pc_i, 2) && cond_o == $past(cond_o, 2) && overflow_o == $past(overflow_o, 2))
		else $error("interrupt return did not restore pushed state");
	pc_count_a: assert property (pc_inc_i && !pc_load_i && !pop |=> pc_o == $past(pc_o) + 14'h1)
		else $error("program counter did not advance");
	reset_state_a: assert property ($rose(rst_b_i) |-> pc_o == `CRS_PC_RST && cond_o && sp_o == `CRS_SP_RST
		&& !int_enable_o && int_req_o == '0 && &int_mask_o && &port_latch_o && port_dir_o == '0)
		else $error("reset values wrong");

	push_seen_c: cover property (push_i && !pop);
	interrupt_return_op_seen_c: cover property (push_i ##1 interrupt_return_op_i);
	reload_seen_c: cover property (stack_bit_clr_i && lvl != `CRS_LVL_TOP);
	fetch_seen_c: cover property (!cond_o ##1 cond_branch_fetch_i);
endmodule // crs_core_regs
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	// ==================================================
	// stimulus and observed signals
	logic core_clk_i = 1'b0, rst_b_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, er;
	logic core_wr = 1'b0, ovf_in = 1'b0, cond_upd = 1'b0, cond_in = 1'b0, brf = 1'b0;
	crs_pkg::crs_dst_e wsel = crs_pkg::crs_dst_acc;
	crs_pkg::crs_ovf_e ovf_op = crs_pkg::crs_ovf_none;
	logic [3:0] wdat = 4'h0;
	logic pc_ld = 1'b0, pc_inc = 1'b0, push = 1'b0, subroutine_return_op = 1'b0, interrupt_return_op = 1'b0, sclr = 1'b0;
	logic [13:0] pc_val = 14'h0000, push_pc = 14'h0000, p;
	logic [9:0] ireq = 10'h000;
	logic [3:0] acc_o, second_o, d_bit_sel_o, aux_col_o, aux_row_o;
	logic [9:0] ram_addr_o, sp_o, int_req_o, int_mask_o, edge_sel_o, timer_ab_o;
	logic overflow_o, cond_o, int_enable_o, c, v;
	logic [13:0] pc_o;
	logic [15:0] port_latch_o, port_dir_o, timer_cd_o;
	logic [11:0] port_mode_o;
	logic [3:0] m [7];
	int err_total = 0, tests_run = 0, lvl;
	always #4 core_clk_i = ~core_clk_i;
	crs_core_regs i_crs_core_regs (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .core_wr_i(core_wr), .core_wr_sel_i(wsel), .core_wr_data_i(wdat),
		.ovf_op_i(ovf_op), .ovf_in_i(ovf_in), .cond_upd_i(cond_upd), .cond_in_i(cond_in),
		.cond_branch_fetch_i(brf), .pc_load_i(pc_ld), .pc_load_val_i(pc_val), .pc_inc_i(pc_inc),
		.push_i(push), .push_pc_i(push_pc), .rtn_i(subroutine_return_op), .interrupt_return_op_i(interrupt_return_op), .stack_bit_clr_i(sclr),
		.int_req_set_i(ireq), .acc_o(acc_o), .second_o(second_o), .ram_addr_o(ram_addr_o),
		.d_bit_sel_o(d_bit_sel_o), .aux_col_o(aux_col_o), .aux_row_o(aux_row_o), .overflow_o(overflow_o),
		.cond_o(cond_o), .pc_o(pc_o), .sp_o(sp_o), .int_enable_o(int_enable_o), .int_req_o(int_req_o),
		.int_mask_o(int_mask_o), .port_latch_o(port_latch_o), .port_dir_o(port_dir_o),
		.port_mode_o(port_mode_o), .edge_sel_o(edge_sel_o), .timer_ab_o(timer_ab_o), .timer_cd_o(timer_cd_o));
	// ==================================================
	// helpers
	function automatic logic [9:0] sp_exp(input int l);
		sp_exp = {4'hF, l[3:0], 2'h3};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// strobes are taken at the next edge, then dropped so they pulse for one cycle
	task automatic cyc();
		@(posedge core_clk_i);
		core_wr <= 1'b0; ovf_op <= crs_pkg::crs_ovf_none; cond_upd <= 1'b0; brf <= 1'b0;
		pc_ld <= 1'b0; pc_inc <= 1'b0; push <= 1'b0; subroutine_return_op <= 1'b0; interrupt_return_op <= 1'b0; sclr <= 1'b0; ireq <= '0;
		#1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic chk_rst();
		chk("pc", pc_o, 0);
		chk("cond", cond_o, 1);
		chk("sp", sp_o, 10'h3FF);
		chk("ie", int_enable_o, 0);
		chk("req", int_req_o, 0);
		chk("mask", int_mask_o, 10'h3FF);
		chk("latch", port_latch_o, 16'hFFFF);
		chk("dir", port_dir_o, 0);
		chk("mode", {port_mode_o, edge_sel_o}, 0);
		chk("timer", {timer_ab_o, timer_cd_o}, 0);
	endtask
	task automatic psh(input logic [13:0] a);
		@(posedge core_clk_i);
		push <= 1'b1; push_pc <= a;
		cyc();
	endtask
	// ==================================================
	// main sequence
	initial begin
		void'($urandom(99829));
		repeat (10) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk_rst();
		// core writes into the data and pointer registers
		for (int i = 0; i < 7; i++) m[i] = 4'h0;
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 7; i++) begin
				@(posedge core_clk_i);
				m[i] = 4'($urandom);
				core_wr <= 1'b1; wsel <= crs_pkg::crs_dst_e'(i); wdat <= m[i];
				cyc();
				chk("acc", {second_o, acc_o}, {m[1], m[0]});
				chk("ram", {d_bit_sel_o, ram_addr_o}, {m[4], m[2][1:0], m[3], m[4]});
				chk("aux", {aux_row_o, aux_col_o}, {m[6], m[5]});
			end
		end
		apb(1'b0, 12'h000, 0);
		chk("acc rd", rd, {28'h0, m[0]});
		apb(1'b0, 12'h050, 0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped rd", rd, 32'h0);
		// overflow operations
		for (int i = 1; i < 5; i++) begin
			@(posedge core_clk_i);
			v = (i == 2) ? 1'b1 : (i == 3) ? 1'b0 : 1'($urandom);
			ovf_op <= crs_pkg::crs_ovf_e'(i); ovf_in <= v;
			cyc();
			chk("ovf", overflow_o, v);
		end
		// condition latch: update, hold, then a fetch overriding a clear
		@(posedge core_clk_i);
		cond_upd <= 1'b1; cond_in <= 1'b0;
		cyc();
		repeat (3) cyc();
		chk("cond hold", cond_o, 0);
		@(posedge core_clk_i);
		cond_upd <= 1'b1; cond_in <= 1'b0; brf <= 1'b1;
		cyc();
		chk("cond fetch", cond_o, 1);
		// program counter is fourteen bits wide
		@(posedge core_clk_i);
		pc_ld <= 1'b1; pc_val <= 14'h3FFF;
		cyc();
		@(posedge core_clk_i);
		pc_inc <= 1'b1;
		cyc();
		chk("pc wrap", pc_o, 0);
		apb(1'b0, 12'h020, 0);
		chk("pc rd", rd, 32'h0);
		// push then interrupt return restores flags, plain return does not
		// third pass returns straight after the push
		for (int k = 0; k < 3; k++) begin
			p = 14'($urandom);
			c = 1'($urandom);
			v = 1'($urandom);
			@(posedge core_clk_i);
			pc_ld <= 1'b1; pc_val <= p; cond_upd <= 1'b1; cond_in <= c;
			ovf_op <= crs_pkg::crs_ovf_arith; ovf_in <= v;
			cyc();
			if (k == 2) begin
				@(posedge core_clk_i);
				push <= 1'b1; push_pc <= p;
				@(posedge core_clk_i);
				push <= 1'b0; interrupt_return_op <= 1'b1;
				cyc();
			end else begin
				psh(p);
				chk("sp push", sp_o, 10'h3FB);
				@(posedge core_clk_i);
				pc_ld <= 1'b1; pc_val <= ~p; cond_upd <= 1'b1; cond_in <= ~c;
				ovf_op <= crs_pkg::crs_ovf_arith; ovf_in <= ~v;
				cyc();
				@(posedge core_clk_i);
				if (k == 0) interrupt_return_op <= 1'b1;
				else subroutine_return_op <= 1'b1;
				cyc();
			end
			chk("pc pop", pc_o, p);
			chk("sp pop", sp_o, 10'h3FF);
			chk("flags pop", {cond_o, overflow_o}, (k != 1) ? {c, v} : {~c, ~v});
		end
		apb(1'b0, 12'h01C, 0);
		chk("flags rd", rd, {30'h0, c, v});
		// sixteen levels with the top bits fixed, then reload
		lvl = 15;
		for (int k = 0; k < 16; k++) begin
			psh(14'($urandom));
			lvl--;
			chk("sp lvl", sp_o, sp_exp(lvl));
		end
		psh(14'h0000);
		@(posedge core_clk_i);
		sclr <= 1'b1;
		cyc();
		chk("sp clr", sp_o, 10'h3FF);
		psh(14'h0000);
		apb(1'b1, 12'h028, 0);
		@(posedge core_clk_i);
		#1;
		chk("sp clr apb", sp_o, 10'h3FF);
		@(posedge core_clk_i);
		ireq <= 10'h004;
		cyc();
		chk("req set", int_req_o, 10'h004);
		// scramble mode settings, then a short reset in mid-run
		for (int a = 12'h02C; a <= 12'h04C; a += 4) apb(1'b1, 12'(a), (a == 12'h038) ? 0 : 32'hFFFF_FFFF);
		chk("dir set", port_dir_o, 16'hFFFF);
		apb(1'b0, 12'h04C, 0);
		chk("timer rd", rd, 32'h0000_FF7F);
		chk("mode wr", {port_mode_o, edge_sel_o}, {12'hB73, 10'h30F});
		chk("timer wr", {timer_ab_o, timer_cd_o}, {10'h3FF, 16'hFF7F});
		@(posedge core_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk_rst();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
